/* File: rtl/pwm_prescaler.sv */
// programmable input clock prescaler giving a one-cycle tick
`timescale 1ns/1ps
module pwm_prescaler
  import pwm_tb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [5:0] cnt;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  logic [5:0] last;

  always_comb begin
    last = 6'((7'h01 << sel) - 7'h01);
    st_nxt = st_r;
    tick = 1'b0;
    // reserved code gives no ticks, so the time base just stops
    if (run && sel != DIV_RESERVED) begin
      if (st_r.cnt >= last) begin
        st_nxt.cnt = 6'h00;
        tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 6'h01;
      end
    end else begin
      st_nxt.cnt = 6'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: rtl/pwm_tb_pkg.sv */
// shared constants and types for the pwm time base and fault control block
package pwm_tb_pkg;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_PTDIV = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h4;
  localparam logic [3:0] ADDR_FCL = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'hC;
  localparam logic [15:0] PERIOD_RST = 16'hFFF8;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] DIV_RESERVED = 3'h7;
  localparam logic [4:0] FSRC_FLT_LAST = 5'h06;
  localparam logic [4:0] FSRC_CMP_FIRST = 5'h08;
  localparam logic [4:0] FSRC_CMP_LAST = 5'h0A;
  localparam int FSRC_POS = 3;
  localparam int FPOL_POS = 2;
  localparam logic [1:0] FMOD_LATCH = 2'h0;
  localparam logic [1:0] FMOD_CYCLE = 2'h1;
  localparam logic [1:0] FMOD_OFF = 2'h3;
  localparam logic [15:0] FCL_RST = 16'h0003;
  localparam int NUM_FLT = 7;
  localparam int NUM_CMP = 3;

  typedef struct packed {
    logic [2:0] div_sel;
    logic [15:0] period;
    logic [4:0] fsrc;
    logic fpol;
    logic [1:0] fmod;
    logic enable;
    logic ovr_hi;
    logic ovr_lo;
  } cfg_t;
endpackage

/* File: rtl/pwm_timebase_fault_control.sv */
// master time base, prescaler select and fault override for one pwm generator
// How it works
// - prescale codes 0..6 divide by 1..64, code 7 reserved, reset divide-by-1
// - sixteen bit master period register, resets to upper ones, low three zero
// - source codes 0..6 pick faults 1..7, codes 8..10 comparators 1..3
// - polarity one means selected source active low, zero active high
// - mode 11 disables fault input, mode 10 reserved
// - mode 01 overrides outputs only while fault is active
// - mode 00 latches override once fault seen
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
module pwm_timebase_fault_control
  import pwm_tb_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic PWM_H_IN,
  input wire logic PWM_L_IN,
  input wire logic [NUM_FLT-1:0] FAULT_IN,
  input wire logic [NUM_CMP-1:0] CMP_IN,
  output logic PWM_HIGH_OUTPUT,
  output logic PWM_LOW_OUTPUT,
  output logic [15:0] MASTER_TIME_BASE_COUNTER,
  output logic PERIOD_TICK
);
  typedef struct packed {
    cfg_t cfg;
    logic [15:0] count;
    logic latched;
    logic ack;
    logic [31:0] rdata;
    logic pwm_h;
    logic pwm_l;
    logic per_tick;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  logic tick;
  logic [NUM_FLT+NUM_CMP-1:0] src_line;
  logic [NUM_FLT+NUM_CMP-1:0] src_hit;
  logic fault_act;
  logic latch_set;
  logic req;
  logic wr_en;
  logic rd_en;
  logic at_period;
  logic [15:0] wval;
  logic [15:0] fcl_rd;
  logic [15:0] period_wr;
  logic [31:0] rd_word;
  logic pwm_h_nxt;
  logic pwm_l_nxt;

  // held clear while disabled, so a restart begins with a whole division
  pwm_prescaler u_pre (
    .clk(MCLK),
    .rst(RST),
    .run(st_r.cfg.enable),
    .sel(st_r.cfg.div_sel),
    .tick(tick)
  );

  // register map, one 32-bit word per register, bits 31:16 always read as zero:
  //   0x0 prescale select in bits 2:0
  //   0x4 master period value
  //   0x8 fault control: source in 7:3, polarity in 2, mode in 1:0
  //   0xC control: enable in 0, override high in 1, override low in 2,
  //       and a read shows counter bits 12:0 in 15:3
  // unmapped offsets read zero and drop writes, but are still answered

  assign req = WB_CYC_I && WB_STB_I && !st_r.ack;
  // a write lands on the edge where the master sees ack, so an abandoned cycle writes nothing
  assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && st_r.ack;
  assign rd_en = req && !WB_WE_I;

  // polarity is applied per line before the code match, so reserved codes
  // match nothing and never fault whatever the polarity
  assign src_line = {CMP_IN, FAULT_IN};
  for (genvar i = 0; i < NUM_FLT + NUM_CMP; i++) begin : g_src
    localparam logic [4:0] SRC_CODE = (i < NUM_FLT) ? 5'(i)
                                                    : 5'(FSRC_CMP_FIRST + i - NUM_FLT);
    assign src_hit[i] = (src_line[i] ^ st_r.cfg.fpol)
      && st_r.cfg.fsrc == SRC_CODE;
  end

  always_comb begin
    fault_act = |src_hit;
    // reserved mode 10 treated as disabled so it can never trap the outputs
    if (st_r.cfg.fmod[1]) begin
      fault_act = 1'b0;
    end
  end

  assign latch_set = fault_act && st_r.cfg.fmod == FMOD_LATCH;
  // a lowered period wraps the counter at once instead of running it out to 0xFFFF
  assign at_period = st_r.count >= st_r.cfg.period;

  for (genvar b = 0; b < 2; b++) begin : g_lane
    assign period_wr[8*b+:8] = WB_SEL_I[b] ? wval[8*b+:8] : st_r.cfg.period[8*b+:8];
  end

  always_comb begin
    fcl_rd = '0;
    fcl_rd[FSRC_POS+:5] = st_r.cfg.fsrc;
    fcl_rd[FPOL_POS] = st_r.cfg.fpol;
    fcl_rd[1:0] = st_r.cfg.fmod;
    wval = WB_DAT_I[15:0];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req;
    st_nxt.per_tick = 1'b0;

    if (st_r.cfg.enable) begin
      if (tick) begin
        if (at_period) begin
          st_nxt.count = 16'h0000;
          st_nxt.per_tick = 1'b1;
        end else begin
          st_nxt.count = st_r.count + 16'h0001;
        end
      end
    end else begin
      st_nxt.count = 16'h0000;
    end

    // the latched fault only clears by rewriting the fault control register
    if (latch_set) begin
      st_nxt.latched = 1'b1;
    end

    if (wr_en) begin
      unique case (WB_ADR_I)
        ADDR_PTDIV: begin
          if (WB_SEL_I[0]) begin
            st_nxt.cfg.div_sel = wval[2:0];
          end
        end
        ADDR_PERIOD: begin
          st_nxt.cfg.period = period_wr;
        end
        ADDR_FCL: begin
          if (WB_SEL_I[0]) begin
            st_nxt.cfg.fsrc = wval[FSRC_POS+:5];
            st_nxt.cfg.fpol = wval[FPOL_POS];
            st_nxt.cfg.fmod = wval[1:0];
            // a fault seen in this very cycle keeps the latch only if latching stays on
            st_nxt.latched = latch_set && wval[1:0] == FMOD_LATCH;
          end
        end
        ADDR_CTRL: begin
          if (WB_SEL_I[0]) begin
            st_nxt.cfg.enable = wval[0];
            st_nxt.cfg.ovr_hi = wval[1];
            st_nxt.cfg.ovr_lo = wval[2];
          end
        end
        default: begin
        end
      endcase
    end

    st_nxt.rdata = rd_word;
    st_nxt.pwm_h = pwm_h_nxt;
    st_nxt.pwm_l = pwm_l_nxt;
  end

  // read data is zero outside the ack cycle, so a late sample never sees stale bits
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_en) begin
      unique case (WB_ADR_I)
        ADDR_PTDIV: rd_word = {29'h0000_0000, st_r.cfg.div_sel};
        ADDR_PERIOD: rd_word = {16'h0000, st_r.cfg.period};
        ADDR_FCL: rd_word = {16'h0000, fcl_rd};
        ADDR_CTRL: rd_word = {16'h0000, st_r.count[12:0], st_r.cfg.ovr_lo, st_r.cfg.ovr_hi,
                              st_r.cfg.enable};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // override follows the live fault or the latch, otherwise the upstream pair passes through
  always_comb begin
    pwm_h_nxt = PWM_H_IN;
    pwm_l_nxt = PWM_L_IN;
    if (fault_act || st_r.latched) begin
      pwm_h_nxt = st_r.cfg.ovr_hi;
      pwm_l_nxt = st_r.cfg.ovr_lo;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
      st_r.cfg.div_sel <= DIV_RST;
      st_r.cfg.period <= PERIOD_RST;
      st_r.cfg.fmod <= FMOD_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign WB_ACK_O = st_r.ack;
  assign WB_DAT_O = st_r.rdata;
  assign PWM_HIGH_OUTPUT = st_r.pwm_h;
  assign PWM_LOW_OUTPUT = st_r.pwm_l;
  assign MASTER_TIME_BASE_COUNTER = st_r.count;
  assign PERIOD_TICK = st_r.per_tick;
endmodule

/* File: tb/pwm_fault_side_model.sv */
// far side: upstream pwm pair and fault and comparator lines
`timescale 1ns/1ps
module pwm_fault_side_model(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] act,
  input wire logic pol,
  output logic [6:0] flt,
  output logic [2:0] cmp,
  output logic hi,
  output logic lo
);
  // inactive lines rest at the idle level of the chosen polarity
  assign {cmp, flt} = pol ? ~act : act;
  // complementary pair, so forcing both high is never mistaken for pass-through
  always_ff @(posedge clk) begin
    if (rst) begin
      hi <= 1'b0;
    end else begin
      hi <= ~hi;
    end
  end
  assign lo = ~hi;
endmodule

/* File: tb/pwm_timebase_fault_control_checker.sv */
// port assertions for the time base and fault block
`timescale 1ns/1ps
module pwm_timebase_fault_control_checker(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [15:0] MASTER_TIME_BASE_COUNTER,
  input wire logic PERIOD_TICK
);
  logic [15:0] c;
  assign c = MASTER_TIME_BASE_COUNTER;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  ack_due_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000) else $error("data");
  dat_upper_a: assert property (WB_DAT_O[31:16] == 16'h0000) else $error("upper data");
  tick_zero_a: assert property (PERIOD_TICK |-> c == 16'h0000) else $error("tick");
  tick_pulse_a: assert property (PERIOD_TICK |=> !PERIOD_TICK) else $error("tick held");
  cnt_step_a: assert property ($changed(c) |-> c == $past(c) + 16'h0001 || c == 16'h0000)
    else $error("count step");
  cover property (PERIOD_TICK);
  cover property (WB_ACK_O && WB_DAT_O != 32'h0000_0000);
  cover property (c == 16'h0003);
endmodule

/* File: tb/pwm_timebase_fault_control_tb.sv */
// bench: registers, time base spacing and fault override modes
`timescale 1ns/1ps
module pwm_timebase_fault_control_tb;
  import pwm_tb_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, we = 0, pol = 0, hi, lo, h_in, l_in, tick, ack;
  logic [3:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [9:0] act = 0;
  logic [6:0] flt;
  logic [2:0] cmp;
  logic [15:0] cnt;
  int error_cnt = 0, compares = 0, n;
  initial forever #5 clk = ~clk;
  pwm_fault_side_model far(.clk(clk), .rst(rst), .act(act), .pol(pol), .flt(flt), .cmp(cmp),
    .hi(h_in), .lo(l_in));
  pwm_timebase_fault_control uut(.MCLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PWM_H_IN(h_in), .PWM_L_IN(l_in), .FAULT_IN(flt), .CMP_IN(cmp),
    .PWM_HIGH_OUTPUT(hi), .PWM_LOW_OUTPUT(lo), .MASTER_TIME_BASE_COUNTER(cnt), .PERIOD_TICK(tick));
  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(logic w, logic [3:0] a, logic [15:0] d, output logic [31:0] q);
    int k;
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    k = 0;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 0;
    if (ack !== 1'b1) begin error_cnt++; wrap_up(); end
    @(posedge clk);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(string what, logic [3:0] a, logic [15:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 16'h0000, q);
    chk(what, {16'h0000, e}, q);
  endtask
  // tick is registered, so edge-sampled spacing equals the period length
  task automatic tick_wait(output int c);
    c = 0;
    do begin @(posedge clk); c++; end while (tick !== 1'b1 && c < 600);
    if (tick !== 1'b1) begin error_cnt++; wrap_up(); end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd("period", ADDR_PERIOD, PERIOD_RST);
    rd("divider", ADDR_PTDIV, 16'h0000);
    rd("fault ctrl", ADDR_FCL, FCL_RST);
    rd("unmapped", 4'h2, 16'h0000);
    wr(ADDR_PERIOD, 16'h0003);
    rd("period", ADDR_PERIOD, 16'h0003);
    for (int d = 0; d < 7; d++) begin
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_PTDIV, 16'(d));
      wr(ADDR_CTRL, 16'h0001);
      tick_wait(n);
      chk("count at wrap", 32'h0000_0000, {16'h0000, cnt});
      tick_wait(n);
      chk("tick spacing", 32'(4 << d), 32'(n));
    end
    wr(ADDR_CTRL, 16'h0006);
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      for (int s = 0; s < 11; s++) begin
        wr(ADDR_FCL, 16'((s << FSRC_POS) | (p << FPOL_POS) | FMOD_CYCLE));
        act <= (s == 7) ? 10'h3FF : 10'h001 << (s < 7 ? s : s - 1);
        repeat (3) @(posedge clk);
        chk("forced pair", {31'h0, s != 7}, {31'h0, hi & lo});
        act <= 10'h000;
        repeat (3) @(posedge clk);
        chk("released pair", 32'h0000_0001, {31'h0, hi ^ lo});
      end
    end
    pol <= 1'b0;
    wr(ADDR_FCL, {14'h0000, FMOD_LATCH});
    act <= 10'h001;
    repeat (3) @(posedge clk);
    act <= 10'h000;
    repeat (3) @(posedge clk);
    chk("latched pair", 32'h0000_0001, {31'h0, hi & lo});
    wr(ADDR_FCL, {14'h0000, FMOD_OFF});
    act <= 10'h001;
    repeat (3) @(posedge clk);
    chk("disabled pair", 32'h0000_0001, {31'h0, hi ^ lo});
    wrap_up();
  end
endmodule
bind pwm_timebase_fault_control pwm_timebase_fault_control_checker chk_i(.MCLK(MCLK), .RST(RST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .MASTER_TIME_BASE_COUNTER(MASTER_TIME_BASE_COUNTER), .PERIOD_TICK(PERIOD_TICK));
